// ### logic/fprc_defines.svh
// constants of the flash power and reset control block
`ifndef FPRC_DEFINES_SVH
`define FPRC_DEFINES_SVH

// clock rate, power-up, status write and deep power-down exit timing
`define FPRC_CLK_MHZ      25
`define FPRC_VSL_US       30
`define FPRC_PUW_US       1000
`define FPRC_SRW_US       5000
`define FPRC_DPD_EXIT_NS  3000

// register byte offsets
`define FPRC_OFS_STATUS   8'h00
`define FPRC_OFS_CYCLE    8'h04
`define FPRC_OFS_LOCK     8'h08
`define FPRC_OFS_LASTCMD  8'h0c

// status field positions
`define FPRC_ST_STATE_LSB 0
`define FPRC_ST_BUSY      2
`define FPRC_ST_WEL       3
`define FPRC_ST_LOCK_LSB  4
`define FPRC_ST_SELRDY    6
`define FPRC_ST_INHDONE   7
`define FPRC_ST_SRW       8
`define FPRC_ST_REJ_LSB   16

// cycle register command bits
`define FPRC_CYC_PROG     0
`define FPRC_CYC_SRW      1
`define FPRC_CYC_DONE     2

// reset values
`define FPRC_RST_LOCK     2'h0
`define FPRC_RST_CODE     8'h00

`endif

// ### logic/fprc_pkg.sv
// types of the flash power and reset control block
package fprc_pkg;

    // power state, gray along standby -> dpd -> exit; exit -> standby flips both bits
    typedef enum logic [1:0] {
        FPRC_STANDBY = 2'h0,
        FPRC_DPD     = 2'h1,
        FPRC_EXIT    = 2'h3,
        FPRC_DRAIN   = 2'h2
    } fprc_state_e;

    // command waiting for select to rise
    typedef enum logic [1:0] {
        FPRC_PEND_NONE = 2'h0,
        FPRC_PEND_DPD  = 2'h1,
        FPRC_PEND_REL  = 2'h2
    } fprc_pend_e;

endpackage

// ### logic/fprc_spi_if.sv
// serial front end to power control core signals
`timescale 1ns/1ps
`default_nettype none
interface fprc_spi_if;
    logic       selRise;   // select went high, one pulse
    logic       byteDone;  // eighth clock of first byte, one pulse
    logic       extraClk;  // clocks seen after the first byte
    logic [7:0] opcode;    // first byte, msb first

    modport rx   (output selRise, output byteDone, output extraClk, output opcode);
    modport core (input selRise, input byteDone, input extraClk, input opcode);
endinterface
`default_nettype wire

// ### logic/fprc_spi_rx.sv
// serial pin sampler and opcode shifter
`timescale 1ns/1ps
`default_nettype none
module fprc_spi_rx (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // serial pins
    input  wire logic spiSelN,
    input  wire logic spiClk,
    input  wire logic serialDataIn,
    // to the core
    fprc_spi_if.rx    spi
);
    logic       selS1, selS2, selS3;   // select synchroniser and history
    logic       clkS1, clkS2, clkS3;   // serial clock synchroniser and history
    logic       dinS1, dinS2;          // data synchroniser, same delay as clock
    logic [3:0] bitCnt_r;              // clocks seen in this frame, saturates
    logic [7:0] shift_r;               // opcode being shifted in
    logic       extra_r;               // a ninth clock has arrived
    logic       active;
    logic       clkRise;

    // two flops on every pin; a third flop on select and clock keeps edge history
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            selS1 <= 1'b1;
            selS2 <= 1'b1;
            selS3 <= 1'b1;
            clkS1 <= 1'b0;
            clkS2 <= 1'b0;
            clkS3 <= 1'b0;
            dinS1 <= 1'b0;
            dinS2 <= 1'b0;
        end else begin
            selS1 <= spiSelN;
            selS2 <= selS1;
            selS3 <= selS2;
            clkS1 <= spiClk;
            clkS2 <= clkS1;
            clkS3 <= clkS2;
            dinS1 <= serialDataIn;
            dinS2 <= dinS1;
        end
    end

    assign active  = !selS2;
    assign clkRise = active && clkS2 && !clkS3;

    // count clocks; data is taken on the rising serial edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bitCnt_r <= 4'h0;
            shift_r  <= 8'h00;
            extra_r  <= 1'b0;
        end else if (!active) begin
            bitCnt_r <= 4'h0;   // a new frame starts clean
            extra_r  <= 1'b0;
        end else if (clkRise) begin
            if (bitCnt_r < 4'h8) begin
                bitCnt_r <= bitCnt_r + 4'h1;
                shift_r  <= {shift_r[6:0], dinS2};
            end else begin
                extra_r  <= 1'b1;   // (R3)
            end
        end
    end

    // select rise sees the frame's counters before they clear
    assign spi.selRise  = selS2 && !selS3;
    assign spi.byteDone = clkRise && (bitCnt_r == 4'h7);
    assign spi.extraClk = extra_r || (clkRise && bitCnt_r == 4'h8);
    assign spi.opcode   = {shift_r[6:0], dinS2};
endmodule
`default_nettype wire

// ### logic/fprc_top.sv
// power state, power-up timing and hardware reset control of a serial flash
//
// Summary of operation
// (R1) deep power-down ignores all but release
// (R2) host sends release with select held low
// (R3) extra clocks after release code reject it
// (R4) standby follows exit delay after select rises
// (R5) release during busy cycle is rejected
// (R6) host waits 30 us after supply before select
// (R7) supply reset holds all logic, no instructions
// (R8) write-class commands ignored during inhibit delay
// (R9) reads accepted once select delay elapsed
// (R10) host withholds writes until both delays end
// (R11) power-up: standby, latch, busy, locks cleared
// (R12) hardware reset pulse clears all lock bits
// (R13) status write finishes, then reset takes effect
// (R14) reset during program or erase restarts logic
// (R15) reset while decoding or idle restarts logic
// (R16) model starts erased, status bits zero
// (R17) host may hold reset low through power
// (R18) host raises select after eighth code bit
// (R19) release code and exit delay are parameters
// (R20) delays counted in reference clock cycles
`include "fprc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fprc_top import fprc_pkg::*; #(
    parameter logic [7:0] RELEASE_CODE = 8'h03,   // (R19)
    parameter logic [7:0] DPD_CODE     = 8'h02,
    parameter logic [7:0] WREN_CODE    = 8'h04,
    parameter logic [7:0] PW_CODE      = 8'h05,
    parameter logic [7:0] PP_CODE      = 8'h06,
    parameter logic [7:0] PE_CODE      = 8'h07,
    parameter logic [7:0] SE_CODE      = 8'h08,
    parameter int unsigned DPD_EXIT_NS = `FPRC_DPD_EXIT_NS,   // (R19)
    parameter int unsigned INHIBIT_CYC = `FPRC_PUW_US * `FPRC_CLK_MHZ,
    parameter int unsigned SRW_CYC     = `FPRC_SRW_US * `FPRC_CLK_MHZ
) (
    // clock and supply-on reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // serial pins and hardware reset pin
    input  wire logic        spiSelN,
    input  wire logic        spiClk,
    input  wire logic        serialDataIn,
    input  wire logic        hwResetN,
    // to the command decoder
    output logic             cmdValid,
    output logic [7:0]       cmdCode,
    output logic             lowPower,
    output logic             busyFlag,
    output logic             writeEnableLatch,
    output logic [1:0]       lockBits
);
    // delays as clock cycle counts (R20)
    localparam int unsigned VSL_CYC  = `FPRC_VSL_US * `FPRC_CLK_MHZ;
    localparam int unsigned EXIT_RAW = (DPD_EXIT_NS * `FPRC_CLK_MHZ + 999) / 1000;
    localparam int unsigned EXIT_CYC = (EXIT_RAW < 1) ? 1 : EXIT_RAW;
    localparam int unsigned POR_MAX  = (VSL_CYC > INHIBIT_CYC) ? VSL_CYC : INHIBIT_CYC;
    localparam logic [23:0] VSL_CNT  = 24'(VSL_CYC);
    localparam logic [23:0] INH_CNT  = 24'(INHIBIT_CYC);
    localparam logic [23:0] POR_CNT  = 24'(POR_MAX);
    localparam logic [23:0] EXIT_CNT = 24'(EXIT_CYC);
    localparam logic [23:0] SRW_CNT  = 24'(SRW_CYC);

    fprc_spi_if spi ();

    fprc_state_e state_r;        // power state
    fprc_pend_e  pend_r;         // command awaiting select rise
    logic [23:0] porCnt_r;       // cycles since (soft) power-on
    logic [23:0] tmr_r;          // exit delay or status write time
    logic        busy_r;         // internal cycle running
    logic        srw_r;          // running cycle is a status write
    logic        wel_r;          // write enable latch
    logic [1:0]  lock_r;         // write lock, lock down
    logic [7:0]  rejCnt_r;       // rejected or ignored commands
    logic [7:0]  lastCmd_r;      // last command passed on
    logic        cmdValid_r;
    logic        hwS1, hwS2;     // reset pin synchroniser
    logic        selectReady;    // select delay over
    logic        inhibitDone;    // write inhibit over
    logic        softRst;        // restart as after supply-on
    logic        wrPend_r;       // ahb write in data phase
    logic [7:0]  wrAddr_r;
    logic [31:0] hrdata_r;
    logic        addrPhase;
    logic        swProg, swSrw, swDone, swLock;

    // write, program and erase class opcodes
    function automatic logic isWriteClass(input logic [7:0] c);
        return (c == WREN_CODE) || (c == PW_CODE) || (c == PP_CODE) ||
               (c == PE_CODE) || (c == SE_CODE);
    endfunction

    fprc_spi_rx u_rx (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .spiSelN      (spiSelN),
        .spiClk       (spiClk),
        .serialDataIn (serialDataIn),
        .spi          (spi.rx)
    );

    // hardware reset pin, two flops before use
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hwS1 <= 1'b1;
            hwS2 <= 1'b1;
        end else begin
            hwS1 <= hwResetN;
            hwS2 <= hwS1;
        end
    end

    // a running status write finishes first (R13)
    assign softRst = (!hwS2 && !(busy_r && srw_r) && state_r != FPRC_DRAIN) ||   // (R14) (R15)
                     (state_r == FPRC_DRAIN && tmr_r == 24'h0);   // (R13)

    // power-on timer; soft reset restarts it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            porCnt_r <= 24'h0;   // (R7)
        end else if (softRst) begin
            porCnt_r <= 24'h0;
        end else if (porCnt_r < POR_CNT) begin
            porCnt_r <= porCnt_r + 24'h1;   // (R20)
        end
    end

    assign selectReady = porCnt_r >= VSL_CNT;   // (R9)
    assign inhibitDone = porCnt_r >= INH_CNT;   // (R8)

    // ahb-lite address phase decode and data phase write strobes
    assign addrPhase = hsel && hready && htrans[1];
    assign swProg = wrPend_r && wrAddr_r == `FPRC_OFS_CYCLE && hwdata[`FPRC_CYC_PROG];
    assign swSrw  = wrPend_r && wrAddr_r == `FPRC_OFS_CYCLE && hwdata[`FPRC_CYC_SRW];
    assign swDone = wrPend_r && wrAddr_r == `FPRC_OFS_CYCLE && hwdata[`FPRC_CYC_DONE];
    assign swLock = wrPend_r && wrAddr_r == `FPRC_OFS_LOCK;

    // register read mux, captured at the address phase
    function automatic logic [31:0] regRead(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            `FPRC_OFS_STATUS: begin
                v[`FPRC_ST_STATE_LSB +: 2] = state_r;
                v[`FPRC_ST_BUSY]           = busy_r;
                v[`FPRC_ST_WEL]            = wel_r;
                v[`FPRC_ST_LOCK_LSB +: 2]  = lock_r;
                v[`FPRC_ST_SELRDY]         = selectReady;
                v[`FPRC_ST_INHDONE]        = inhibitDone;
                v[`FPRC_ST_SRW]            = srw_r;
                v[`FPRC_ST_REJ_LSB +: 8]   = rejCnt_r;
            end
            `FPRC_OFS_LOCK:    v[1:0] = lock_r;
            `FPRC_OFS_LASTCMD: v[7:0] = lastCmd_r;
            default:           v = 32'h0;   // cycle and unmapped read zero
        endcase
        return v;
    endfunction

    // bus slave pipeline: no wait states, always okay
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
            hrdata_r <= 32'h0;
        end else begin
            wrPend_r <= addrPhase && hwrite;
            if (addrPhase) begin
                wrAddr_r <= {haddr[7:2], 2'b00};
                if (!hwrite) begin
                    hrdata_r <= regRead({haddr[7:2], 2'b00});
                end
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    // power state machine and serial command gating
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= FPRC_STANDBY;   // (R11)
            pend_r     <= FPRC_PEND_NONE;
            tmr_r      <= 24'h0;
            cmdValid_r <= 1'b0;
            lastCmd_r  <= `FPRC_RST_CODE;
            rejCnt_r   <= 8'h00;   // (R16)
        end else if (softRst) begin
            state_r    <= FPRC_STANDBY;   // (R14) (R15)
            pend_r     <= FPRC_PEND_NONE;
            tmr_r      <= 24'h0;
            cmdValid_r <= 1'b0;
        end else begin
            cmdValid_r <= 1'b0;
            // timer: exit delay or status write time
            if (swSrw && !busy_r && state_r == FPRC_STANDBY) begin
                tmr_r <= SRW_CNT;
            end else if (tmr_r != 24'h0) begin
                tmr_r <= tmr_r - 24'h1;
            end
            case (state_r)
                FPRC_STANDBY: begin
                    if (!hwS2 && busy_r && srw_r) begin
                        state_r <= FPRC_DRAIN;   // (R13)
                    end else if (spi.byteDone) begin
                        if (!selectReady) begin
                            rejCnt_r <= rejCnt_r + 8'h1;   // (R7)
                        end else if (spi.opcode == DPD_CODE) begin
                            if (busy_r) begin
                                rejCnt_r <= rejCnt_r + 8'h1;
                            end else begin
                                pend_r <= FPRC_PEND_DPD;
                            end
                        end else if (spi.opcode == RELEASE_CODE) begin
                            rejCnt_r <= rejCnt_r + 8'h1;   // nothing to release
                        end else if (isWriteClass(spi.opcode) && !inhibitDone) begin
                            rejCnt_r <= rejCnt_r + 8'h1;   // (R8)
                        end else begin
                            cmdValid_r <= 1'b1;   // (R9)
                            lastCmd_r  <= spi.opcode;
                        end
                    end else if (spi.selRise) begin
                        pend_r <= FPRC_PEND_NONE;
                        // single-byte command needs exactly eight clocks
                        if (pend_r == FPRC_PEND_DPD && !spi.extraClk) begin
                            state_r <= FPRC_DPD;
                        end
                    end
                end
                FPRC_DPD: begin
                    if (spi.byteDone) begin
                        if (spi.opcode == RELEASE_CODE && !busy_r) begin   // (R5)
                            pend_r <= FPRC_PEND_REL;
                        end else begin
                            rejCnt_r <= rejCnt_r + 8'h1;   // (R1)
                        end
                    end else if (spi.selRise) begin
                        pend_r <= FPRC_PEND_NONE;
                        if (pend_r == FPRC_PEND_REL && !spi.extraClk) begin   // (R3)
                            state_r <= FPRC_EXIT;
                            tmr_r   <= EXIT_CNT;   // (R4)
                        end
                    end
                end
                FPRC_EXIT: begin
                    // select stays high; anything sent is dropped
                    if (spi.byteDone) begin
                        rejCnt_r <= rejCnt_r + 8'h1;
                    end
                    if (tmr_r == 24'h1) begin
                        state_r <= FPRC_STANDBY;   // (R4)
                    end
                end
                FPRC_DRAIN: begin
                    // status write completes, then soft reset fires
                    pend_r <= FPRC_PEND_NONE;   // (R13)
                end
                default: begin
                    state_r <= FPRC_STANDBY;
                end
            endcase
        end
    end

    // busy flag and status write flag
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;   // (R11)
            srw_r  <= 1'b0;
        end else if (softRst) begin
            busy_r <= 1'b0;   // (R14)
            srw_r  <= 1'b0;
        end else if (!busy_r && state_r == FPRC_STANDBY && (swProg || swSrw)) begin
            busy_r <= 1'b1;
            srw_r  <= swSrw;
        end else if (busy_r && ((srw_r && tmr_r == 24'h1) || (!srw_r && swDone))) begin
            busy_r <= 1'b0;
            srw_r  <= 1'b0;
        end
    end

    // write enable latch: set by enable, cleared at cycle end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wel_r <= 1'b0;   // (R11)
        end else if (softRst) begin
            wel_r <= 1'b0;
        end else if (spi.byteDone && state_r == FPRC_STANDBY && selectReady &&
                     inhibitDone && spi.opcode == WREN_CODE) begin
            wel_r <= 1'b1;   // set wins over a same-cycle clear (R8)
        end else if (busy_r && ((srw_r && tmr_r == 24'h1) || (!srw_r && swDone))) begin
            wel_r <= 1'b0;
        end
    end

    // lock bits: writable, any reset clears them
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lock_r <= `FPRC_RST_LOCK;   // (R11)
        end else if (!hwS2) begin
            lock_r <= `FPRC_RST_LOCK;   // (R12)
        end else if (swLock) begin
            lock_r <= hwdata[1:0];
        end
    end

    // outputs to the command decoder, all from flops except lowPower, decoded from state_r
    assign cmdValid         = cmdValid_r;
    assign cmdCode          = lastCmd_r;
    assign lowPower         = state_r == FPRC_DPD;
    assign busyFlag         = busy_r;
    assign writeEnableLatch = wel_r;
    assign lockBits         = lock_r;

    // hsize unused: words only
    logic unusedSize;
    assign unusedSize = ^hsize;
endmodule
`default_nettype wire

// ### dv/fprc_top_sva.sv
// assertion checker for the flash power and reset control top
`timescale 1ns/1ps
`default_nettype none
module fprc_top_sva #(
    parameter logic [7:0]  RELEASE_CODE = 8'h03,
    parameter logic [7:0]  WREN_CODE    = 8'h04,
    parameter logic [7:0]  PW_CODE      = 8'h05,
    parameter logic [7:0]  PP_CODE      = 8'h06,
    parameter logic [7:0]  PE_CODE      = 8'h07,
    parameter logic [7:0]  SE_CODE      = 8'h08,
    parameter int unsigned INHIBIT_CYC  = 25000
) (
    // clock and resets
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       hwResetN,
    // pins and decoder side
    input wire logic       spiSelN,
    input wire logic       cmdValid,
    input wire logic [7:0] cmdCode,
    input wire logic       lowPower,
    input wire logic       busyFlag,
    input wire logic       writeEnableLatch,
    input wire logic [1:0] lockBits
);
    localparam int SEL_CYC = 30 * 25;  // select delay at 25 MHz
    logic [31:0] upCnt_r;  // cycles since reset, saturating
    logic        isWrite;  // write-class code

    // raw pin restarts it; behind the dut count only while a running status write holds off the soft reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            upCnt_r <= 32'h0;
        end else if (!hwResetN) begin
            upCnt_r <= 32'h0;
        end else if (upCnt_r != 32'hffffffff) begin
            upCnt_r <= upCnt_r + 32'h1;
        end
    end

    assign isWrite = cmdCode inside {WREN_CODE, PW_CODE, PP_CODE, PE_CODE, SE_CODE};

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_dpdIgnore;
        lowPower && cmdValid |-> cmdCode == RELEASE_CODE;
    endproperty
    a_dpdIgnore: assert property (p_dpdIgnore)
        else $error("dpd passed cmd");
    property p_inhibit;
        cmdValid && upCnt_r < INHIBIT_CYC |-> !isWrite;
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("write in inhibit");
    property p_selDelay;
        cmdValid |-> upCnt_r >= SEL_CYC;
    endproperty
    a_selDelay: assert property (p_selDelay)
        else $error("cmd before select delay");
    property p_lockClr;
        !hwResetN [*6] |-> lockBits == 2'h0 && !lowPower;
    endproperty
    a_lockClr: assert property (p_lockClr)
        else $error("pin reset ignored");
    property p_powerUp;
        $rose(rst_n) |-> !lowPower && !busyFlag && !writeEnableLatch && lockBits == 2'h0;
    endproperty
    a_powerUp: assert property (p_powerUp)
        else $error("power-up state");
    property p_exitOnSel;
        $fell(lowPower) |-> spiSelN && $past(spiSelN, 2);
    endproperty
    a_exitOnSel: assert property (p_exitOnSel)
        else $error("exit while selected");
    property p_busyRel;
        busyFlag && cmdValid |-> cmdCode != RELEASE_CODE;
    endproperty
    a_busyRel: assert property (p_busyRel)
        else $error("release while busy");
    property p_dpdOnRise;
        $rose(lowPower) |-> spiSelN && !busyFlag;
    endproperty
    a_dpdOnRise: assert property (p_dpdOnRise)
        else $error("dpd while selected");

    // main scenarios reached
    c_release: cover property ($fell(lowPower));
    c_dpd: cover property ($rose(lowPower));
    c_busyReset: cover property (busyFlag && !hwResetN);
endmodule
`default_nettype wire

// ### dv/fprc_spi_host.sv
// serial host model driving select, clock and data pins
`timescale 1ns/1ps
`default_nettype none
module fprc_spi_host (
    // serial pins
    output var logic spiSelN,
    output var logic spiClk,
    output var logic serialDataIn
);
    localparam time HALF = 160ns;  // 320 ns serial period

    // deselected, clock parked low between frames
    initial begin
        spiSelN = 1'b1;
        spiClk = 1'b0;
        serialDataIn = 1'b0;
    end

    // one frame; 7 ns offset keeps pins off mclk edges
    task automatic sendFrame(input logic [7:0] code, input int nClk);
        int i;
        #7ns spiSelN = 1'b0;  // low for the whole frame
        for (i = 0; i < nClk; i++) begin
            serialDataIn = code[7 - (i % 8)];  // msb first
            #HALF spiClk = 1'b1;
            #HALF spiClk = 1'b0;
        end
        #HALF spiSelN = 1'b1;  // right after the last bit
        serialDataIn = ~serialDataIn;  // released line shows no stale bit
    endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// testbench top for the flash power and reset control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // row: idle wait, frame, pulses, power state
    typedef struct {
        int         pre;
        logic [7:0] code;
        int         nClk;
        int         expV;
        logic       expLp;
    } fprc_row_s;

    logic        mclk, rst_n, hsel, hwrite, hreadyout, hresp, hwResetN;
    logic [7:0]  haddr, cmdCode;
    logic [1:0]  htrans, lockBits;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata;
    logic        spiSelN, spiClk, serialDataIn;
    logic        cmdValid, lowPower, busyFlag, writeEnableLatch;
    int          n_errors, compares, cvCnt;
    fprc_row_s   rows [8];

    // short delays keep the run brief
    fprc_top #(.INHIBIT_CYC(2000), .SRW_CYC(50)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .spiSelN(spiSelN), .spiClk(spiClk), .serialDataIn(serialDataIn),
        .hwResetN(hwResetN), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .lowPower(lowPower), .busyFlag(busyFlag),
        .writeEnableLatch(writeEnableLatch), .lockBits(lockBits));
    fprc_spi_host u_host (.spiSelN(spiSelN), .spiClk(spiClk), .serialDataIn(serialDataIn));

    // 25 MHz clock
    initial mclk = 1'b0;
    always #20ns mclk = ~mclk;
    // count command pulses
    always @(posedge mclk) if (cmdValid === 1'b1) cvCnt++;

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one word; waits on hready in each phase
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge mclk);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] m, e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        chk(x & m, e);
    endtask

    // frame, then select held high past exit delay
    task automatic frame(input logic [7:0] c, input int n, input int expV);
        int nv;
        nv = cvCnt;
        u_host.sendFrame(c, n);
        repeat (120) @(posedge mclk);
        chk(32'(cvCnt - nv), 32'(expV));
    endtask

    task automatic pinReset();
        @(posedge mclk);
        hwResetN <= 1'b0;
        repeat (10) @(posedge mclk);
        hwResetN <= 1'b1;
        repeat (6) @(posedge mclk);
    endtask

    initial begin
        rst_n = 1'b0;
        hwResetN = 1'b0;
        hsel = 1'b1;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        rows = '{'{0, 8'h0b, 8, 0, 1'b0},     // too early
                 '{700, 8'h04, 8, 0, 1'b0},   // wren inhibited
                 '{0, 8'h0b, 8, 1, 1'b0},     // read ok
                 '{1300, 8'h04, 8, 1, 1'b0},  // wren ok
                 '{0, 8'h02, 8, 0, 1'b1},     // dpd
                 '{0, 8'h04, 8, 0, 1'b1},     // ignored
                 '{0, 8'h03, 9, 0, 1'b1},     // extra clock
                 '{0, 8'h03, 8, 0, 1'b0}};    // release
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        hwResetN <= 1'b1;
        rdChk(8'h00, 32'hffffffff, 32'h0);
        foreach (rows[i]) begin
            repeat (rows[i].pre) @(posedge mclk);
            frame(rows[i].code, rows[i].nClk, rows[i].expV);
            chk({31'h0, lowPower}, {31'h0, rows[i].expLp});
        end
        rdChk(8'h00, 32'h3, 32'h0);
        rdChk(8'h0c, 32'hff, 32'h4);
        rdChk(8'h10, 32'hffffffff, 32'h0);
        $display("test table done");
        // release while busy
        wr(8'h04, 32'h1);
        frame(8'h03, 8, 0);
        chk({31'h0, busyFlag}, 32'h1);
        wr(8'h04, 32'h4);
        @(posedge mclk);
        chk({30'h0, busyFlag, writeEnableLatch}, 32'h0);
        $display("test busy release done");
        // pin reset in program, locks set
        wr(8'h08, 32'h3);
        rdChk(8'h08, 32'hffffffff, 32'h3);
        wr(8'h04, 32'h1);
        pinReset();
        rdChk(8'h08, 32'hffffffff, 32'h0);
        rdChk(8'h00, 32'h3f, 32'h0);
        $display("test pin reset done");
        // pin reset in status write
        wr(8'h04, 32'h2);
        pinReset();
        rdChk(8'h00, 32'h137, 32'h106);
        repeat (60) @(posedge mclk);
        rdChk(8'h00, 32'h13f, 32'h0);
        $display("test status write done");
        // mid-run supply reset
        wr(8'h08, 32'h2);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rdChk(8'h00, 32'hffffffff, 32'h0);
        rdChk(8'h08, 32'hffffffff, 32'h0);
        $display("test second reset done");
        report_and_stop();
    end

    // hang guard
    initial begin
        #800us;
        n_errors++;
        report_and_stop();
    end
endmodule

bind fprc_top fprc_top_sva #(
    .RELEASE_CODE(RELEASE_CODE), .WREN_CODE(WREN_CODE), .PW_CODE(PW_CODE),
    .PP_CODE(PP_CODE), .PE_CODE(PE_CODE), .SE_CODE(SE_CODE), .INHIBIT_CYC(INHIBIT_CYC)
) u_sva (
    .mclk(mclk), .rst_n(rst_n), .hwResetN(hwResetN), .spiSelN(spiSelN),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .lowPower(lowPower), .busyFlag(busyFlag),
    .writeEnableLatch(writeEnableLatch), .lockBits(lockBits));
`default_nettype wire
